// ---- design/nic_top.sv ----
// Local design decisions: the placing of the registers and the Avalon-MM slave port.
module nic_top (
   input  wire logic                      clk_i,             // cpu clock
   input  wire logic                      rst_n_i,           // async reset
   input  wire logic [nic_pkg::AW-1:0]    avs_address_i,     // word addr
   input  wire logic                      avs_read_i,        // read
   input  wire logic                      avs_write_i,       // write
   input  wire logic [3:0]                avs_byteenable_i,  // lanes
   input  wire logic [31:0]               avs_writedata_i,   // wr data
   output logic [31:0]                    avs_readdata_o,    // rd data
   output logic                           avs_waitrequest_o, // stall
   input  wire logic [nic_pkg::NVEC-1:0]  per_irq_i,         // periph
   input  wire logic [nic_pkg::NPIN-1:0]  ext_pin_i,         // pins
   input  wire logic                      clock_fail_i,      // safe osc
   input  wire logic                      supply_warn_i,     // low vdd
   input  wire logic                      instr_boundary_i,  // insn end
   input  wire logic                      trap_exec_i,       // trap insn
   input  wire logic                      halt_i,            // halted
   input  wire logic                      core_ack_i,        // stacked
   input  wire logic                      return_from_irq_instr_i,            // return
   input  wire logic [1:0]                popped_level_i,    // popped cc
   input  wire logic                      cc_write_i,        // sw write
   input  wire logic [1:0]                cc_level_i,        // new bits
   output logic                           take_req_o,        // enter
   output logic [15:0]                    vector_o,          // vector
   output logic                           stack_ctx_o,       // push regs
   output logic [1:0]                     level_o,           // hi,lo bit
   output logic                           wake_o             // leave halt
);
   import nic_pkg::*;

   typedef struct packed {
      nic_state_t      st;
      logic [1:0]      kind;
      logic [1:0]      lvl;
      logic [1:0]      wlvl;
      logic [3:0]      idx;
      logic [15:0]     vec;
      logic [3:0]      depth;
      logic            take;
      logic            stack;
      logic            wake;
      logic            trap_p;
      logic            cf_p;
      logic            sw_p;
      logic [NGRP-1:0] ext_p;
      logic            cf_flag;
      logic            cf_d;
      logic            sw_d;
      logic [NPIN-1:0] pins_d;
      logic [7:0]      sense;
      logic [7:0]      pinsel;
      logic [7:0]      sysctl;
      logic [1:0]      bcnt;
      logic            bwait;
      logic [31:0]     rdata;
   } nic_top_st_t;

   // (R17) reset is the entry pending out of reset
   localparam nic_top_st_t S_RST = '{st: ST_TAKE, kind: K_RST,
                                     lvl: LVL3, wlvl: LVL3,
                                     vec: VEC_RESET, take: 1'b1,
                                     bwait: 1'b1, default: '0};

   nic_top_st_t         s_reg, s_next;
   nic_arb_if           arb ();
   logic [7:0]          mem_rdata;
   logic [2*NVEC-1:0]   prio;
   logic                mem_we;
   logic                wr_ok;
   logic                rd_ok;
   logic                entry;
   logic [NGRP-1:0]     grp_edge;
   logic [NGRP-1:0]     grp_low;
   logic [NVEC-1:0]     pend;
   logic [NVEC-1:0]     allow;
   logic [1:0]          eidx;
   logic [31:0]         rmux;

   // bus completes in the cycle waitrequest is low
   assign wr_ok  = avs_write_i && !s_reg.bwait;
   assign rd_ok  = avs_read_i && !s_reg.bwait;
   assign mem_we = wr_ok && avs_byteenable_i[0] &&
                   (avs_address_i < REG_SENSE);
   assign entry  = (s_reg.st == ST_TAKE) && core_ack_i;
   assign eidx   = 2'(s_reg.idx - SRC_EXT);

   // (R19) per-group sense; (R21) selected pins ORed
   for (genvar g = 0; g < NGRP; g++) begin : g_grp
      logic [PPG-1:0] sel;
      logic [PPG-1:0] now;
      logic [PPG-1:0] old;
      logic [1:0]     sns;
      assign sel = s_reg.pinsel[PPG*g +: PPG];
      assign now = ext_pin_i[PPG*g +: PPG];
      assign old = s_reg.pins_d[PPG*g +: PPG];
      assign sns = s_reg.sense[2*g +: 2];
      assign grp_low[g]  = (sns == SNS_LOW) && |(~now & sel);
      assign grp_edge[g] = (sns[SNS_RISE_B] && |(now & ~old & sel)) ||
                           (sns[SNS_FALL_B] && |(~now & old & sel));
   end

   // (R12) latched and level requests merged per slot
   always_comb begin
      pend = per_irq_i;
      // (R1) events gated by their own enable
      pend[SRC_CLK] = per_irq_i[SRC_CLK] |
                      (s_reg.cf_p & s_reg.sysctl[SYS_CF_EN]);
      pend[SRC_SUP] = per_irq_i[SRC_SUP] |
                      (s_reg.sw_p & s_reg.sysctl[SYS_SW_EN]);
      for (int g = 0; g < NGRP; g++) begin
         pend[int'(SRC_EXT) + g] = per_irq_i[int'(SRC_EXT) + g] |
                                   s_reg.ext_p[g] | grp_low[g];
      end
   end

   // (R22) concurrent mode blocks pre-emption while in a routine;
   // a halted core is woken only by sources that can leave halt
   always_comb begin
      allow = halt_i ? HALT_OK : {NVEC{1'b1}};
      if (!s_reg.sysctl[SYS_NEST] && s_reg.depth != 4'h0) begin
         allow = '0;
      end
   end

   assign arb.pend  = pend;
   assign arb.allow = allow;
   assign arb.prio  = prio;
   assign arb.cur   = s_reg.lvl;

   nic_arbiter u_arb (
      .a (arb.arb)
   );

   nic_prio_mem u_prio (
      .clk_i    (clk_i),
      .rst_n_i  (rst_n_i),
      .we_i     (mem_we),
      .addr_i   (avs_address_i[1:0]),
      .wdata_i  (avs_writedata_i[7:0]),
      .rdata_o  (mem_rdata),
      .levels_o (prio)
   );

   // read mux; status shows the level, nesting depth and pending set
   always_comb begin
      case (avs_address_i)
         REG_SENSE:  rmux = {24'h0, s_reg.sense};
         REG_PINSEL: rmux = {24'h0, s_reg.pinsel};
         REG_SYSINT: begin
            rmux = {24'h0, s_reg.sysctl};
            rmux[SYS_CF_FLAG] = s_reg.cf_flag;
            rmux[SYS_SW_FLAG] = supply_warn_i;
         end
         REG_STATUS: rmux = {12'h0, pend, s_reg.depth, s_reg.lvl};
         default:    rmux = {24'h0, mem_rdata};
      endcase
   end

   // next state of the whole block
   always_comb begin
      s_next = s_reg;
      s_next.pins_d = ext_pin_i;
      s_next.cf_d   = clock_fail_i;
      s_next.sw_d   = supply_warn_i;
      // (R15) trap or a halt-capable request wakes the core
      s_next.wake = halt_i && (s_reg.trap_p || |(pend & HALT_OK));

      // two wait cycles: priority bytes come from a registered memory
      if (!s_reg.bwait) begin
         s_next.bwait = 1'b1;
         s_next.bcnt  = 2'h0;
      end else if (avs_read_i || avs_write_i) begin
         s_next.bcnt = s_reg.bcnt + 2'h1;
         if (s_reg.bcnt == BUS_WAIT) begin
            s_next.bwait = 1'b0;
            s_next.rdata = rmux;
         end
      end
      if (wr_ok && avs_byteenable_i[0]) begin
         case (avs_address_i)
            REG_SENSE:  s_next.sense  = avs_writedata_i[7:0];
            REG_PINSEL: s_next.pinsel = avs_writedata_i[7:0];
            REG_SYSINT: s_next.sysctl = avs_writedata_i[7:0] & SYS_WMASK;
            default:    s_next.sense  = s_reg.sense;
         endcase
      end
      // a read clears the flag only once the main clock is back
      if (rd_ok && avs_address_i == REG_SYSINT && !clock_fail_i) begin
         s_next.cf_flag = 1'b0;
      end
      if (clock_fail_i) begin
         s_next.cf_flag = 1'b1;
      end

      case (s_reg.st)
         ST_IDLE: begin
            // (R6) decide only at an instruction boundary
            if (instr_boundary_i) begin
               // (R13) trap ranks above maskable sources
               if (s_reg.trap_p) begin
                  s_next.st    = ST_TAKE;
                  s_next.take  = 1'b1;
                  s_next.kind  = K_TRAP;
                  s_next.wlvl  = LVL3;
                  // (R7) trap stacks the context
                  s_next.stack = 1'b1;
                  s_next.vec   = VEC_TRAP;
               end else if (arb.win_v) begin
                  s_next.st    = ST_TAKE;
                  s_next.take  = 1'b1;
                  s_next.kind  = K_MASK;
                  s_next.wlvl  = arb.win_lvl;
                  s_next.idx   = arb.win_idx;
                  // (R7) maskable entry stacks the context
                  s_next.stack = 1'b1;
                  // (R3) slot order follows vector address
                  s_next.vec   = VEC_TOP - {11'h0, arb.win_idx, 1'b0};
               end
            end
         end
         ST_TAKE: begin
            // (R24) request and vector hold until the core acks
            if (core_ack_i) begin
               s_next.st    = ST_IDLE;
               s_next.take  = 1'b0;
               s_next.stack = 1'b0;
            end
         end
         default: s_next.st = ST_IDLE;
      endcase

      if (entry) begin
         // (R8) maskable entry takes the stored level;
         // (R14) non-maskables go to level 3
         s_next.lvl = (s_reg.kind == K_MASK) ? s_reg.wlvl : LVL3;
         // (R2) depth tracks nesting; reset starts from main
         if (s_reg.kind == K_RST) begin
            s_next.depth = 4'h0;
         end else if (s_reg.depth != DEPTH_MAX) begin
            s_next.depth = s_reg.depth + 4'h1;
         end
         if (s_reg.kind == K_TRAP) begin
            s_next.trap_p = 1'b0;
         end else if (s_reg.kind == K_MASK) begin
            // (R20) edge requests clear on entry
            if (s_reg.idx == SRC_CLK) begin
               s_next.cf_p = 1'b0;
            end
            if (s_reg.idx == SRC_SUP) begin
               s_next.sw_p = 1'b0;
            end
            if (s_reg.idx >= SRC_EXT &&
                s_reg.idx < SRC_EXT + 4'(NGRP)) begin
               s_next.ext_p[eidx] = 1'b0;
            end
         end
      end else if (return_from_irq_instr_i) begin
         // (R10) popped bits restore the previous level
         s_next.lvl = popped_level_i;
         if (s_reg.depth != 4'h0) begin
            s_next.depth = s_reg.depth - 4'h1;
         end
      end else if (cc_write_i) begin
         s_next.lvl = cc_level_i;
      end

      // new events are set after the clears so none is lost
      // (R16) trap instruction raises the trap source
      if (trap_exec_i) begin
         s_next.trap_p = 1'b1;
      end
      // (R1) latch only while the enable is set
      if (clock_fail_i && !s_reg.cf_d && s_reg.sysctl[SYS_CF_EN]) begin
         s_next.cf_p = 1'b1;
      end
      if ((supply_warn_i != s_reg.sw_d) && s_reg.sysctl[SYS_SW_EN]) begin
         s_next.sw_p = 1'b1;
      end
      s_next.ext_p = s_next.ext_p | grp_edge;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_reg <= S_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   // all outputs come straight from the state register
   assign avs_readdata_o    = s_reg.rdata;
   assign avs_waitrequest_o = s_reg.bwait;
   assign take_req_o        = s_reg.take;
   // (R9) vector for the core's fetch
   assign vector_o          = s_reg.vec;
   assign stack_ctx_o       = s_reg.stack;
   // (R4) (R5) level code as cc bits five and three
   assign level_o           = s_reg.lvl;
   assign wake_o            = s_reg.wake;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);

   a_nmi_level3: assert property (entry && s_reg.kind != K_MASK
      |=> level_o == LVL3) // R14
      else $error("non-maskable entry did not set level 3");
   a_mask_level: assert property (entry && s_reg.kind == K_MASK
      |=> level_o == $past(s_reg.wlvl)) // R8
      else $error("maskable entry loaded the wrong level");
   a_return_from_irq_instr_level: assert property (!entry && return_from_irq_instr_i
      |=> level_o == $past(popped_level_i)) // R10
      else $error("return did not restore the level");
   a_take_bound: assert property ($rose(take_req_o)
      |-> $past(instr_boundary_i)) // R6
      else $error("entry requested off an instruction boundary");
   a_take_hold: assert property (take_req_o && !core_ack_i
      |=> take_req_o && $stable(vector_o)) // R24
      else $error("take request dropped before ack");
   a_reset_nostack: assert property (take_req_o && vector_o == VEC_RESET
      |-> !stack_ctx_o) // R14
      else $error("reset entry asked for stacking");
   a_mask_above: assert property ($rose(take_req_o) && stack_ctx_o &&
      vector_o != VEC_TRAP
      |-> nic_rank(s_reg.wlvl) > nic_rank($past(s_reg.lvl))) // R18
      else $error("maskable taken at or below current level");
   a_trap_clear: assert property (entry && s_reg.kind == K_TRAP &&
      !trap_exec_i |=> !s_reg.trap_p) // R16
      else $error("trap request not cleared on entry");
   a_sup_gate: assert property ($rose(s_reg.sw_p)
      |-> $past(s_reg.sysctl[SYS_SW_EN])) // R1
      else $error("supply warning latched while disabled");
   a_halt_wake: assert property (halt_i && s_reg.trap_p
      |=> wake_o) // R15
      else $error("pending trap did not wake the core");
   a_bus_answer: assert property ((avs_read_i || avs_write_i) &&
      avs_waitrequest_o |-> ##[1:2] !avs_waitrequest_o)
      else $error("bus request not answered in time");

   c_reset_entry: cover property (entry && s_reg.kind == K_RST);
   c_trap_entry:  cover property (entry && s_reg.kind == K_TRAP);
   c_nested_two:  cover property (s_reg.depth == 4'h2);
   c_halt_wake:   cover property ($rose(wake_o));
endmodule : nic_top

// ---- inc/nic_pkg.sv ----
// Notes on behaviour
// (R1) Clock-fail and supply-warn requests need their own enable and an unmasked core.
// (R2) Four software levels let higher-level requests pre-empt lower-level routines.
// (R3) Sixteen fixed vectors at the top of memory, ordered by hardware priority.
// (R4) Current level lives in two condition-code bits, positions five and three.
// (R5) Codes: level0=10, level1=01, level2=00, level3=11; level 3 masks all.
// (R6) Servicing waits for the current instruction to finish.
// (R7) Entry stacks program counter, index, accumulator and condition code.
// (R8) Maskable entry loads level bits from the vector's stored priority.
// (R9) After stacking, the program counter takes the vector, then fetch begins.
// (R10) Return pops the level bits so the interrupted level resumes.
// (R11) Highest software level wins; ties go to the higher hardware priority.
// (R12) Unserviced requests stay latched until they become the highest.
// (R13) Reset and trap rank above every maskable source.
// (R14) Non-maskables ignore level bits; trap stacks, reset does not; level 3.
// (R15) Non-maskable sources wake the core from halt.
// (R16) The trap instruction raises the trap source, serviced like others.
// (R17) Reset wins overall; its routine runs at level 3.
// (R18) Maskable taken only if enabled and above current level, else pending.
// (R19) Pin interrupts wake from halt; sensitivity set by software.
// (R20) Edge-triggered pin requests latch and clear on routine entry.
// (R21) Selected pins sharing one line are combined by OR.
// (R22) Hardware order fixed; nested mode pre-empts, concurrent mode does not.
// (R23) Writing the level-0 code to a priority field keeps the old value.
// (R24) Vector and take request offered at a boundary; core acks after stacking.
package nic_pkg;
   localparam int NVEC = 14;   // maskable vectors
   localparam int NGRP = 4;    // external pin groups
   localparam int PPG  = 2;    // pins per group
   localparam int NPIN = NGRP * PPG;
   localparam int AW   = 3;    // word address width
   // register word indices
   localparam logic [AW-1:0] REG_SENSE  = 3'h4;
   localparam logic [AW-1:0] REG_PINSEL = 3'h5;
   localparam logic [AW-1:0] REG_SYSINT = 3'h6;
   localparam logic [AW-1:0] REG_STATUS = 3'h7;
   // system-integrity bit positions
   localparam int SYS_CF_FLAG = 1;
   localparam int SYS_CF_EN   = 2;
   localparam int SYS_SW_FLAG = 5;
   localparam int SYS_SW_EN   = 6;
   localparam int SYS_NEST    = 7;
   localparam logic [7:0] SYS_WMASK = 8'hc4;
   localparam logic [7:0] PRIO_RST  = 8'hff;
   localparam logic [7:0] PRIO3_RO  = 8'hf0;
   // level codes of the condition-code bits
   localparam logic [1:0] LVL0 = 2'h2;
   localparam logic [1:0] LVL1 = 2'h1;
   localparam logic [1:0] LVL2 = 2'h0;
   localparam logic [1:0] LVL3 = 2'h3;
   localparam int CC_HI_POS = 5;
   localparam int CC_LO_POS = 3;
   // vectors and source slots
   localparam logic [15:0] VEC_RESET = 16'hfffe;
   localparam logic [15:0] VEC_TRAP  = 16'hfffc;
   localparam logic [15:0] VEC_TOP   = 16'hfffa;
   localparam logic [3:0]  SRC_CLK   = 4'h1;
   localparam logic [3:0]  SRC_EXT   = 4'h2;
   localparam logic [3:0]  SRC_SUP   = 4'hc;
   localparam logic [NVEC-1:0] HALT_OK = 14'h003c;
   // pin sense field: bit0 rising, bit1 falling, 00 low level
   localparam int SNS_RISE_B = 0;
   localparam int SNS_FALL_B = 1;
   localparam logic [1:0] SNS_LOW = 2'h0;
   // entry kinds and bus timing
   localparam logic [1:0] K_MASK = 2'h0;
   localparam logic [1:0] K_TRAP = 2'h1;
   localparam logic [1:0] K_RST  = 2'h2;
   localparam logic [1:0] BUS_WAIT = 2'h1;
   localparam logic [3:0] DEPTH_MAX = 4'hf;

   typedef enum logic [0:0] {ST_IDLE, ST_TAKE} nic_state_t;

   // order of levels: level code to a comparable rank
   function automatic logic [1:0] nic_rank(input logic [1:0] c);
      case (c)
         LVL0:    nic_rank = 2'h0;
         LVL1:    nic_rank = 2'h1;
         LVL2:    nic_rank = 2'h2;
         default: nic_rank = 2'h3;
      endcase
   endfunction : nic_rank
endpackage : nic_pkg

// ---- inc/nic_arb_if.sv ----
// request set offered to the arbiter and the winner it returns
interface nic_arb_if;
   logic [nic_pkg::NVEC-1:0]   pend;
   logic [nic_pkg::NVEC-1:0]   allow;
   logic [2*nic_pkg::NVEC-1:0] prio;
   logic [1:0]                 cur;
   logic                       win_v;
   logic [3:0]                 win_idx;
   logic [1:0]                 win_lvl;
   modport arb (input pend, allow, prio, cur,
                output win_v, win_idx, win_lvl);
   modport ctl (output pend, allow, prio, cur,
                input win_v, win_idx, win_lvl);
endinterface : nic_arb_if

// ---- design/nic_prio_mem.sv ----
module nic_prio_mem (
   input  wire logic                     clk_i,    // cpu clock
   input  wire logic                     rst_n_i,  // async reset
   input  wire logic                     we_i,     // write strobe
   input  wire logic [1:0]               addr_i,   // priority byte
   input  wire logic [7:0]               wdata_i,  // write byte
   output logic [7:0]                    rdata_o,  // registered read
   output logic [2*nic_pkg::NVEC-1:0]    levels_o  // all fields
);
   import nic_pkg::*;

   typedef struct packed {
      logic [3:0][7:0] mem;
      logic [7:0]      rdata;
   } nic_mem_st_t;

   localparam nic_mem_st_t S_RST = '{mem: {4{PRIO_RST}}, rdata: 8'h00};

   nic_mem_st_t s_reg, s_next;
   logic [7:0]  merged;
   logic [31:0] flat;

   // (R23) level-0 writes kept out
   for (genvar f = 0; f < 4; f++) begin : g_fld
      assign merged[2*f +: 2] = (wdata_i[2*f +: 2] == LVL0) ?
                                s_reg.mem[addr_i][2*f +: 2] :
                                wdata_i[2*f +: 2];
   end

   // read data registered; the top nibble of the last byte stays set
   always_comb begin
      s_next = s_reg;
      s_next.rdata = s_reg.mem[addr_i];
      if (we_i) begin
         s_next.mem[addr_i] = (addr_i == 2'h3) ? (merged | PRIO3_RO)
                                               : merged;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_reg <= S_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   assign flat     = s_reg.mem;
   assign levels_o = flat[2*NVEC-1:0];
   assign rdata_o  = s_reg.rdata;

   a_lvl0_keep: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      we_i && wdata_i[5:4] == LVL0 |=> s_reg.mem[$past(addr_i)][5:4] ==
      $past(s_reg.mem[addr_i][5:4])) // R23
      else $error("level-0 write changed a priority field");
endmodule : nic_prio_mem

// ---- design/nic_arbiter.sv ----
module nic_arbiter (
   nic_arb_if.arb a  // request set and winner
);
   import nic_pkg::*;

   logic [1:0] best;

   // (R11) software level first, ties to lower slot
   always_comb begin
      best      = nic_rank(a.cur);
      a.win_v   = 1'b0;
      a.win_idx = 4'h0;
      a.win_lvl = LVL0;
      // descending scan with >= lets the lower slot win a tie
      for (int n = NVEC - 1; n >= 0; n--) begin
         // (R18) only strictly above the current level
         if (a.pend[n] && a.allow[n] &&
             nic_rank(a.prio[2*n +: 2]) > nic_rank(a.cur) &&
             (!a.win_v || nic_rank(a.prio[2*n +: 2]) >= best)) begin
            a.win_v   = 1'b1;
            a.win_idx = 4'(n);
            a.win_lvl = a.prio[2*n +: 2];
            best      = nic_rank(a.prio[2*n +: 2]);
         end
      end
   end
endmodule : nic_arbiter

// ---- tb/nic_core_model.sv ----
// core side: ends instructions and acks each take after stacking
module nic_core_model (
   input  wire logic clk_i,      // cpu clock
   input  wire logic rst_n_i,    // async reset
   input  wire logic halt_i,     // core halted
   input  wire logic slow_i,     // stretch stacking
   input  wire logic take_req_i, // entry request
   output logic      boundary_o, // insn end
   output logic      ack_o       // stacking done
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] cnt;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         boundary_o <= 1'b0;
      end else begin
         boundary_o <= !boundary_o && !halt_i && !take_req_i;
      end
   end
   // stack then ack
   // slow mode stretches stacking so the held outputs are seen to stand
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt   <= 2'h0;
         ack_o <= 1'b0;
      end else begin
         ack_o <= 1'b0;
         if (take_req_i && !ack_o) begin
            cnt <= cnt + 2'h1;
            if (cnt >= (slow_i ? 2'h3 : 2'h0)) begin
               ack_o <= 1'b1;
               cnt   <= 2'h0;
            end
         end
      end
   end
endmodule : nic_core_model

// ---- tb/nic_tb.sv ----
module nic_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import nic_pkg::*;
   logic        clk_i, rst_n_i, avs_read_i, avs_write_i, halt_i, slow_i;
   logic        trap_exec_i, return_from_irq_instr_i, cc_write_i, core_ack_i;
   logic        instr_boundary_i, avs_waitrequest_o, take_req_o;
   logic        stack_ctx_o, wake_o, clock_fail_i, supply_warn_i;
   logic [1:0]  popped_level_i, cc_level_i, level_o;
   logic [2:0]  avs_address_i;
   logic [7:0]  ext_pin_i;
   logic [13:0] per_irq_i;
   logic [15:0] vector_o;
   logic [31:0] avs_writedata_i, avs_readdata_o, q;
   int          failures, cmp_count;
   nic_top DUT (.clk_i, .rst_n_i, .avs_address_i, .avs_read_i,
      .avs_write_i, .avs_byteenable_i(4'h1), .avs_writedata_i,
      .avs_readdata_o, .avs_waitrequest_o, .per_irq_i, .ext_pin_i,
      .clock_fail_i, .supply_warn_i, .instr_boundary_i,
      .trap_exec_i, .halt_i, .core_ack_i, .return_from_irq_instr_i, .popped_level_i,
      .cc_write_i, .cc_level_i, .take_req_o, .vector_o, .stack_ctx_o,
      .level_o, .wake_o);
   nic_core_model u_core (.clk_i, .rst_n_i, .halt_i, .slow_i,
      .take_req_i(take_req_o), .boundary_o(instr_boundary_i),
      .ack_o(core_ack_i));
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   task end_of_test;
      $display("checks %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_of_test
   task chk(input string nm, input logic [31:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // a bound that runs out ends the run as a mismatch
   task hang;
      failures++;
      $display("Error wait bound expected 1 seen 0");
      end_of_test();
   endtask : hang
   // avalon access: hold the request until waitrequest is seen low
   task bus(input logic wr, input logic [2:0] a, input logic [7:0] d);
      int n;
      @(posedge clk_i);
      avs_read_i      <= !wr;
      avs_write_i     <= wr;
      avs_address_i   <= a;
      avs_writedata_i <= {24'h0, d};
      // waitrequest and read data are taken at the rising edge only
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (avs_waitrequest_o !== 1'b0 && n < 20);
      if (avs_waitrequest_o !== 1'b0) hang();
      q = avs_readdata_o;
      {avs_read_i, avs_write_i} <= 2'h0;
   endtask : bus
   // one-cycle core event: 0 level write, 1 return, 2 trap
   task core(input int k, input logic [1:0] l);
      @(posedge clk_i);
      cc_write_i     <= (k == 0);
      return_from_irq_instr_i         <= (k == 1);
      trap_exec_i    <= (k == 2);
      cc_level_i     <= l;
      popped_level_i <= l;
      @(posedge clk_i);
      {cc_write_i, return_from_irq_instr_i, trap_exec_i} <= 3'h0;
   endtask : core
   task wt(input logic b);
      int n;
      for (n = 0; n < 60 && take_req_o !== b; n++) @(negedge clk_i);
      if (take_req_o !== b) hang();
   endtask : wt
   task take(input logic [15:0] v, input logic s, input logic [1:0] l);
      wt(1'b1);
      chk("vector", vector_o, {16'h0, v});
      chk("stack", stack_ctx_o, {31'h0, s});
      wt(1'b0);
      chk("level", level_o, {30'h0, l});
   endtask : take
   task none(input int n);
      logic seen;
      seen = 1'b0;
      repeat (n) begin
         @(negedge clk_i);
         if (take_req_o !== 1'b0) seen = 1'b1;
      end
      chk("idle", {31'h0, seen}, 32'h0);
   endtask : none
   // main sequence: each test drives the core link; all but the trap test also use the register bus
   initial begin
      {rst_n_i, avs_read_i, avs_write_i, halt_i, slow_i} = 5'h0;
      {trap_exec_i, return_from_irq_instr_i, cc_write_i, clock_fail_i, supply_warn_i} = 5'h0;
      {popped_level_i, cc_level_i, avs_address_i} = 7'h0;
      {ext_pin_i, per_irq_i, avs_writedata_i} = 54'h0;
      repeat (2) @(posedge clk_i);
      rst_n_i <= 1'b1;
      take(VEC_RESET, 1'b0, LVL3);
      bus(1'b0, 3'h0, 8'h00);
      chk("prio0", q, 32'hff);
      bus(1'b1, 3'h1, 8'hcf);
      bus(1'b1, 3'h1, 8'h64);
      bus(1'b0, 3'h1, 8'h00);
      chk("prio1", q, 32'h44);
      $display("test reset and priority done");
      core(0, LVL0);
      @(posedge clk_i) per_irq_i <= 14'h00c0;
      take(16'hffee, 1'b1, LVL2);
      @(posedge clk_i) per_irq_i <= 14'h0180;
      none(20);
      bus(1'b1, REG_SYSINT, 8'h80);
      take(16'hffea, 1'b1, LVL3);
      @(posedge clk_i) per_irq_i <= 14'h0080;
      core(1, LVL2);
      repeat (2) @(negedge clk_i);
      chk("return_from_irq_instr level", level_o, {30'h0, LVL2});
      core(1, LVL0);
      take(16'hffec, 1'b1, LVL1);
      @(posedge clk_i) per_irq_i <= 14'h0;
      core(1, LVL0);
      $display("test nesting done");
      bus(1'b1, REG_SENSE, 8'h01);
      bus(1'b1, REG_PINSEL, 8'h01);
      @(posedge clk_i) ext_pin_i <= 8'h01;
      @(posedge clk_i) ext_pin_i <= 8'h00;
      take(16'hfff6, 1'b1, LVL3);
      core(1, LVL0);
      none(20);
      $display("test pin edge done");
      core(0, LVL3);
      slow_i <= 1'b1;
      halt_i <= 1'b1;
      core(2, LVL3);
      repeat (3) @(negedge clk_i);
      chk("wake", {31'h0, wake_o}, 32'h1);
      @(posedge clk_i) halt_i <= 1'b0;
      take(VEC_TRAP, 1'b1, LVL3);
      $display("test trap done");
      core(1, LVL0);
      bus(1'b1, REG_SYSINT, 8'hc4);
      @(posedge clk_i) clock_fail_i <= 1'b1;
      take(16'hfff8, 1'b1, LVL3);
      core(1, LVL0);
      @(posedge clk_i) supply_warn_i <= 1'b1;
      take(16'hffe2, 1'b1, LVL3);
      core(1, LVL0);
      @(posedge clk_i) clock_fail_i <= 1'b0;
      bus(1'b0, REG_SYSINT, 8'h00);
      chk("sysint", q, 32'he6);
      bus(1'b0, REG_SYSINT, 8'h00);
      chk("sysint clr", q, 32'he4);
      $display("test system events done");
      end_of_test();
   end
endmodule : nic_tb
